// ==== inc/msc_pkg.sv ====
// Shared constants and carrier types of the system-control block
package msc_pkg;
  // Register byte offsets
  localparam logic [5:0] CLOCK_MODE_OFS = 6'h00;
  localparam logic [5:0] PORT_A_WAKE_OFS = 6'h04;
  localparam logic [5:0] PORT_B_WAKE_OFS = 6'h08;
  localparam logic [5:0] INT_ENABLE_OFS = 6'h0C;
  localparam logic [5:0] INT_REQUEST_OFS = 6'h10;
  localparam logic [5:0] AUX_CONTROL_OFS = 6'h14;
  localparam logic [5:0] EDGE_SELECT_OFS = 6'h18;
  localparam logic [5:0] TIMER_CTRL_OFS = 6'h1C;
  localparam logic [5:0] TIMER_COUNT_OFS = 6'h20;
  localparam logic [5:0] PIN5_CTRL_OFS = 6'h24;
  localparam logic [5:0] STATUS_OFS = 6'h28;
  // Clock mode register fields
  localparam int CLK_EXT_RST_BIT = 0;
  localparam int CLK_HIGH_EN_BIT = 1;
  localparam int CLK_LOW_EN_BIT = 2;
  localparam int CLK_HIGH_SEL_BIT = 4;
  localparam int CLK_DIV_LSB = 5;
  // Auxiliary control fields
  localparam int AUX_WDT_LSB = 0;
  localparam int AUX_LVR_DIS_BIT = 2;
  localparam int AUX_WDT_EN_BIT = 3;
  localparam int AUX_FAST_WAKE_BIT = 5;
  // Edge select, timer control, pin 5 control, request bits
  localparam int EDGE_FALL_BIT = 0;
  localparam int TMR_EN_BIT = 7;
  localparam int PIN5_OUT_VAL_BIT = 0;
  localparam int PIN5_OUT_MODE_BIT = 1;
  localparam int IRQ_TIMER_BIT = 2;
  // Reset values
  localparam logic [7:0] CLOCK_MODE_RST = 8'h04;
  localparam logic [7:0] AUX_CONTROL_RST = 8'h00;
  localparam logic [7:0] EDGE_SELECT_RST = 8'h00;
  localparam logic [7:0] TIMER_CTRL_RST = 8'h08;
  localparam logic [7:0] PIN5_CTRL_RST = 8'h00;
  // Timing counts in low-speed oscillator periods
  localparam logic [15:0] WAKE_FAST_TICKS = 16'h002D;

  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_COUNT = 2'b01,
    W_DONE = 2'b11
  } msc_wake_e;

  typedef struct packed {
    logic isr_enter;
    logic isr_return;
    logic gie_set;
    logic gie_clear;
    logic wdt_clear;
    logic stop_sys;
    logic stop_exe;
  } msc_cpu_ev_s;

  typedef struct packed {
    logic high_sel;
    logic [2:0] div;
    logic high_en;
    logic low_en;
  } msc_clk_ctl_s;
endpackage : msc_pkg

// ==== rtl/msc_system_control.sv ====
// System control: clocking, wake-up, interrupt gating, timer, watchdog, LOW_VOLTAGE_RESET
//
// Implementation choices: the address map and register access over Avalon-MM.
module msc_system_control #(
  parameter int WDT_TICKS_0 = 8192,
  parameter int WDT_TICKS_1 = 16384,
  parameter int WDT_TICKS_2 = 65536,
  parameter int WDT_TICKS_3 = 262144,
  parameter int SLOW_WAKE_TICKS = 1024
) (
  input wire logic clk, // 200 MHz system clock
  input wire logic rstn, // Async reset, active low
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [5:0] avs_address, // Avalon byte address
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait
  input wire msc_pkg::msc_cpu_ev_s cpu_ev, // Core events and sleep levels
  input wire logic low_tick, // One pulse per slow osc period
  input wire logic timer_tick, // Timer count pulse
  input wire logic por_done, // Power-on sequence complete
  input wire logic [7:0] port_a_pins, // Port A pin levels
  input wire logic [7:0] port_b_pins, // Port B pin levels
  input wire logic lvr_trip, // Supply below threshold
  input wire logic [7:0] irq_sources, // Other request pulses
  output msc_pkg::msc_clk_ctl_s clk_ctl, // Clock source control
  output logic port_a_pin5_out, // Pin five output level
  output logic port_a_pin5_oe, // Pin five output enable
  output logic external_reset_req, // Reset from pin five
  output logic lvr_reset, // Low-voltage reset
  output logic wdt_reset, // Watchdog timeout pulse
  output logic wake_resume, // Resume pulse after wake
  output logic int_pending, // Interrupt to core
  output logic cpu_hang // Clock lost by bad switch
);
  localparam int NSYNC = 17;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] clk_mode;
    logic [7:0] wake_a;
    logic [7:0] wake_b;
    logic [7:0] ier;
    logic [7:0] irq;
    logic [7:0] aux;
    logic [7:0] edge_sel;
    logic [7:0] tmr_ctrl;
    logic [7:0] pin5_ctrl;
    logic [15:0] tmr_cnt;
    logic tmr_prev;
    logic gie;
    logic gie_saved;
    logic hang;
    logic por_seen;
    logic [17:0] wdt_cnt;
    logic wdt_pulse;
    logic [NSYNC-1:0] sy1;
    logic [NSYNC-1:0] sy2;
    logic [NSYNC-1:0] sy3;
    logic [NSYNC-1:0] filt;
    logic [15:0] wake_cnt;
    msc_pkg::msc_wake_e wst;
    logic resume;
    logic ext_rst;
    logic lvr_rst;
  } msc_state_s;

  msc_state_s st;
  msc_state_s next_st;

  logic wr;
  logic in_sleep;
  logic cur_bit;
  logic tmr_evt;
  logic [7:0] wd;
  logic [17:0] wdt_limit;
  logic [15:0] wake_target;
  logic [15:0] pin_change;
  logic wake_start;

  assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
  assign avs_readdata = st.rdata;
  assign clk_ctl.high_sel = st.clk_mode[msc_pkg::CLK_HIGH_SEL_BIT];
  assign clk_ctl.div = st.clk_mode[msc_pkg::CLK_DIV_LSB +: 3];
  assign clk_ctl.high_en = st.clk_mode[msc_pkg::CLK_HIGH_EN_BIT];
  assign clk_ctl.low_en = st.clk_mode[msc_pkg::CLK_LOW_EN_BIT];
  assign port_a_pin5_out = 1'b0;
  assign port_a_pin5_oe = st.pin5_ctrl[msc_pkg::PIN5_OUT_MODE_BIT] &
    ~st.pin5_ctrl[msc_pkg::PIN5_OUT_VAL_BIT] &
    ~st.clk_mode[msc_pkg::CLK_EXT_RST_BIT];
  assign external_reset_req = st.ext_rst;
  assign lvr_reset = st.lvr_rst;
  assign wdt_reset = st.wdt_pulse;
  assign wake_resume = st.resume;
  assign int_pending = st.gie & |(st.ier & st.irq);
  assign cpu_hang = st.hang;

  always_comb begin
    next_st = st;
    // Write lands at the edge where waitrequest is seen low
    wr = avs_write & st.ack;
    wd = avs_writedata[7:0];
    in_sleep = cpu_ev.stop_sys | cpu_ev.stop_exe;
    next_st.ack = (avs_read | avs_write) & ~st.ack;

    // Three-stage pin sync; a level counts once stages 2 and 3 agree
    next_st.sy1 = {lvr_trip, port_b_pins, port_a_pins};
    next_st.sy2 = st.sy1;
    next_st.sy3 = st.sy2;
    next_st.filt = (~(st.sy2 ^ st.sy3) & st.sy3) |
      ((st.sy2 ^ st.sy3) & st.filt);

    // Read path, captured on the first cycle of a request
    if ((avs_read | avs_write) & ~st.ack) begin
      case (avs_address)
        msc_pkg::CLOCK_MODE_OFS: next_st.rdata = {24'h0, st.clk_mode};
        msc_pkg::PORT_A_WAKE_OFS: next_st.rdata = {24'h0, st.wake_a};
        msc_pkg::PORT_B_WAKE_OFS: next_st.rdata = {24'h0, st.wake_b};
        msc_pkg::INT_ENABLE_OFS: next_st.rdata = {24'h0, st.ier};
        msc_pkg::INT_REQUEST_OFS: next_st.rdata = {24'h0, st.irq};
        msc_pkg::AUX_CONTROL_OFS: next_st.rdata = {24'h0, st.aux};
        msc_pkg::EDGE_SELECT_OFS: next_st.rdata = {24'h0, st.edge_sel};
        msc_pkg::TIMER_CTRL_OFS: next_st.rdata = {24'h0, st.tmr_ctrl};
        msc_pkg::TIMER_COUNT_OFS: next_st.rdata = {16'h0, st.tmr_cnt};
        msc_pkg::PIN5_CTRL_OFS: next_st.rdata = {24'h0, st.pin5_ctrl};
        msc_pkg::STATUS_OFS: next_st.rdata = {26'h0,
          st.wst != msc_pkg::W_IDLE,
          st.lvr_rst, st.por_seen, st.hang, st.gie_saved, st.gie};
        default: next_st.rdata = 32'h0;
      endcase
    end

    if (wr) begin
      case (avs_address)
        msc_pkg::CLOCK_MODE_OFS: begin
          next_st.clk_mode = wd;
          // Slow-to-fast switch that kills the slow osc in one write,
          // or any slow selection with slow osc off, loses the clock
          if (!wd[msc_pkg::CLK_LOW_EN_BIT] &&
              (!wd[msc_pkg::CLK_HIGH_SEL_BIT] ||
               !st.clk_mode[msc_pkg::CLK_HIGH_SEL_BIT])) begin
            next_st.hang = 1'b1;
          end
        end
        msc_pkg::PORT_A_WAKE_OFS: next_st.wake_a = wd;
        msc_pkg::PORT_B_WAKE_OFS: next_st.wake_b = wd;
        msc_pkg::INT_ENABLE_OFS: next_st.ier = wd;
        msc_pkg::AUX_CONTROL_OFS: next_st.aux = wd;
        msc_pkg::EDGE_SELECT_OFS: next_st.edge_sel = wd;
        msc_pkg::TIMER_CTRL_OFS: next_st.tmr_ctrl = wd;
        msc_pkg::PIN5_CTRL_OFS: next_st.pin5_ctrl = wd;
        default: ;
      endcase
    end

    // Timer: registered selected bit compared with current one
    cur_bit = st.tmr_cnt[st.tmr_ctrl[3:0]];
    next_st.tmr_prev = cur_bit;
    if (st.edge_sel[msc_pkg::EDGE_FALL_BIT]) begin
      tmr_evt = st.tmr_prev & ~cur_bit;
    end else begin
      tmr_evt = ~st.tmr_prev & cur_bit;
    end
    if (wr && avs_address == msc_pkg::TIMER_COUNT_OFS) begin
      // Restart: no edge against the old count
      next_st.tmr_cnt = avs_writedata[15:0];
      next_st.tmr_prev = avs_writedata[st.tmr_ctrl[3:0]];
    end else if (timer_tick && st.tmr_ctrl[msc_pkg::TMR_EN_BIT]) begin
      next_st.tmr_cnt = st.tmr_cnt + 16'h0001;
    end

    // Requests: a new event wins over a software clear
    if (wr && avs_address == msc_pkg::INT_REQUEST_OFS) begin
      next_st.irq = wd;
    end
    next_st.irq = next_st.irq | irq_sources |
      (8'(tmr_evt) << msc_pkg::IRQ_TIMER_BIT);

    // Global enable
    if (cpu_ev.isr_enter) begin
      next_st.gie_saved = st.gie;
      next_st.gie = 1'b0;
    end else if (cpu_ev.isr_return) begin
      next_st.gie = st.gie_saved;
    end else if (cpu_ev.gie_set) begin
      next_st.gie = 1'b1;
    end else if (cpu_ev.gie_clear) begin
      next_st.gie = 1'b0;
    end

    // Watchdog
    case (st.aux[msc_pkg::AUX_WDT_LSB +: 2])
      2'b00: wdt_limit = 18'(WDT_TICKS_0 - 1);
      2'b01: wdt_limit = 18'(WDT_TICKS_1 - 1);
      2'b10: wdt_limit = 18'(WDT_TICKS_2 - 1);
      default: wdt_limit = 18'(WDT_TICKS_3 - 1);
    endcase
    next_st.wdt_pulse = 1'b0;
    if (!st.clk_mode[msc_pkg::CLK_LOW_EN_BIT] ||
        !st.aux[msc_pkg::AUX_WDT_EN_BIT]) begin
      next_st.wdt_cnt = st.wdt_cnt;
    end else if (cpu_ev.wdt_clear) begin
      next_st.wdt_cnt = 18'h00000;
    end else if (low_tick) begin
      if (st.wdt_cnt >= wdt_limit) begin
        next_st.wdt_cnt = 18'h00000;
        next_st.wdt_pulse = 1'b1;
      end else begin
        next_st.wdt_cnt = st.wdt_cnt + 18'h00001;
      end
    end

    // Wake-up from sleep
    pin_change = (next_st.filt[15:0] ^ st.filt[15:0]) &
      {st.wake_b, st.wake_a};
    wake_start = in_sleep && |pin_change;
    if (st.aux[msc_pkg::AUX_FAST_WAKE_BIT]) begin
      wake_target = msc_pkg::WAKE_FAST_TICKS;
    end else begin
      wake_target = 16'(SLOW_WAKE_TICKS);
    end
    next_st.resume = 1'b0;
    case (st.wst)
      msc_pkg::W_IDLE: begin
        if (wake_start) begin
          next_st.wst = msc_pkg::W_COUNT;
          next_st.wake_cnt = 16'h0000;
        end
      end
      msc_pkg::W_COUNT: begin
        if (low_tick) begin
          next_st.wake_cnt = st.wake_cnt + 16'h0001;
          if (st.wake_cnt + 16'h0001 >= wake_target) begin
            next_st.wst = msc_pkg::W_DONE;
            next_st.resume = 1'b1;
          end
        end
      end
      msc_pkg::W_DONE: next_st.wst = msc_pkg::W_IDLE;
      default: next_st.wst = msc_pkg::W_IDLE;
    endcase

    // Pin five reset and low-voltage reset
    next_st.ext_rst = st.clk_mode[msc_pkg::CLK_EXT_RST_BIT] &
      ~st.pin5_ctrl[msc_pkg::PIN5_OUT_MODE_BIT] & ~st.filt[5];
    if (por_done) begin
      next_st.por_seen = 1'b1;
    end
    next_st.lvr_rst = st.por_seen & ~st.aux[msc_pkg::AUX_LVR_DIS_BIT] &
      ~in_sleep & st.filt[16];
  end

  // Interrupt enable and request bits keep whatever they hold through reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st.ack <= 1'b0;
      st.rdata <= 32'h0;
      st.clk_mode <= msc_pkg::CLOCK_MODE_RST;
      st.wake_a <= 8'h00;
      st.wake_b <= 8'h00;
      st.aux <= msc_pkg::AUX_CONTROL_RST;
      st.edge_sel <= msc_pkg::EDGE_SELECT_RST;
      st.tmr_ctrl <= msc_pkg::TIMER_CTRL_RST;
      st.pin5_ctrl <= msc_pkg::PIN5_CTRL_RST;
      st.tmr_cnt <= 16'h0000;
      st.tmr_prev <= 1'b0;
      st.gie <= 1'b0;
      st.gie_saved <= 1'b0;
      st.hang <= 1'b0;
      st.por_seen <= 1'b0;
      st.wdt_cnt <= 18'h00000;
      st.wdt_pulse <= 1'b0;
      st.sy1 <= '0;
      st.sy2 <= '0;
      st.sy3 <= '0;
      st.filt <= '0;
      st.wake_cnt <= 16'h0000;
      st.wst <= msc_pkg::W_IDLE;
      st.resume <= 1'b0;
      st.ext_rst <= 1'b0;
      st.lvr_rst <= 1'b0;
    end else begin
      st <= next_st; // ier and irq skip the reset branch
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_wake_needs_enable: assert property (
    st.wst == msc_pkg::W_IDLE &&
      !(in_sleep && |((next_st.filt[15:0] ^ st.filt[15:0]) &
      {st.wake_b, st.wake_a})) |=> st.wst == msc_pkg::W_IDLE)
    else $error("wake started from a disabled pin");
  a_pin5_no_high: assert property (
    port_a_pin5_oe |-> !port_a_pin5_out &&
      !st.clk_mode[msc_pkg::CLK_EXT_RST_BIT])
    else $error("pin five driven while high or reset input");
  a_ext_reset_gate: assert property (
    $rose(external_reset_req) |->
      $past(st.clk_mode[msc_pkg::CLK_EXT_RST_BIT]) && $past(!st.filt[5]))
    else $error("external reset without enable or low pin");
  a_isr_entry_gie: assert property (
    cpu_ev.isr_enter |=> !int_pending && $past(st.gie) == st.gie_saved)
    else $error("isr entry left interrupts enabled");
  a_reti_restores: assert property (
    cpu_ev.isr_return && !cpu_ev.isr_enter |=> st.gie == $past(st.gie_saved))
    else $error("return did not restore global enable");
  a_bad_switch_hang: assert property (
    wr && avs_address == msc_pkg::CLOCK_MODE_OFS && wd == 8'h50 &&
      !st.clk_mode[msc_pkg::CLK_HIGH_SEL_BIT] |=> cpu_hang)
    else $error("slow-to-fast switch with osc off did not hang");
  a_safe_switch: assert property (
    wr && avs_address == msc_pkg::CLOCK_MODE_OFS && wd == 8'h36 && !cpu_hang
      |=> clk_ctl.high_sel && clk_ctl.div == 3'b001 && clk_ctl.low_en &&
      !cpu_hang)
    else $error("safe switch value misdecoded");
  a_wdt_frozen: assert property (
    !st.clk_mode[msc_pkg::CLK_LOW_EN_BIT] |=>
      $stable(st.wdt_cnt) && !wdt_reset)
    else $error("watchdog ran with slow oscillator off");
  a_wdt_period: assert property (
    wdt_reset |-> $past(st.wdt_cnt) == $past(wdt_limit) &&
      st.wdt_cnt == 18'h00000)
    else $error("watchdog fired at wrong count");
  a_timer_edge: assert property (
    st.tmr_prev != cur_bit &&
      cur_bit != st.edge_sel[msc_pkg::EDGE_FALL_BIT]
      |=> st.irq[msc_pkg::IRQ_TIMER_BIT])
    else $error("timer edge did not raise request");
  a_lvr_gating: assert property (
    lvr_reset |-> $past(st.por_seen) &&
      !$past(st.aux[msc_pkg::AUX_LVR_DIS_BIT]) && $past(!in_sleep))
    else $error("low-voltage reset while not armed");
  a_fast_wake_time: assert property (
    wake_resume && st.aux[msc_pkg::AUX_FAST_WAKE_BIT] &&
      $stable(st.aux) |-> st.wake_cnt == msc_pkg::WAKE_FAST_TICKS)
    else $error("fast wake resumed at wrong count");
endmodule : msc_system_control

// ==== testbench/test_msc_system_control.sv ====
// Self-checking bench of the system-control block
module test_msc_system_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] EV_ENTER = 7'h40;
  localparam logic [6:0] EV_RET = 7'h20;
  localparam logic [6:0] EV_SET = 7'h10;
  localparam logic [6:0] EV_CLR = 7'h08;
  localparam logic [6:0] EV_WDC = 7'h04;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  msc_pkg::msc_cpu_ev_s cpu_ev = '0;
  logic low_tick = 1'b0;
  logic timer_tick = 1'b0;
  logic por_done = 1'b0;
  logic [7:0] port_a_pins = 8'hFF;
  logic [7:0] port_b_pins = 8'hFF;
  logic lvr_trip = 1'b0;
  logic [7:0] irq_sources = 8'h00;
  msc_pkg::msc_clk_ctl_s clk_ctl;
  logic port_a_pin5_out, port_a_pin5_oe, external_reset_req, lvr_reset;
  logic wdt_reset, wake_resume, int_pending, cpu_hang;
  int bad_count = 0;
  int n_checks = 0;
  int wdt_hits = 0;
  int wake_hits = 0;
  int per[4] = '{16, 32, 64, 128};
  int n;
  logic [31:0] rd;

  msc_system_control #(.WDT_TICKS_0(16), .WDT_TICKS_1(32), .WDT_TICKS_2(64),
    .WDT_TICKS_3(128), .SLOW_WAKE_TICKS(8)) u_dut (.clk(clk), .rstn(rstn),
    .avs_read(avs_read), .avs_write(avs_write), .avs_address(avs_address),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_ev(cpu_ev), .low_tick(low_tick),
    .timer_tick(timer_tick), .por_done(por_done), .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins), .lvr_trip(lvr_trip),
    .irq_sources(irq_sources), .clk_ctl(clk_ctl),
    .port_a_pin5_out(port_a_pin5_out), .port_a_pin5_oe(port_a_pin5_oe),
    .external_reset_req(external_reset_req), .lvr_reset(lvr_reset),
    .wdt_reset(wdt_reset), .wake_resume(wake_resume),
    .int_pending(int_pending), .cpu_hang(cpu_hang));

  always #2.5 clk = ~clk;

  // Pulses counted mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (wdt_reset === 1'b1) wdt_hits++;
    if (wake_resume === 1'b1) wake_hits++;
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // Waitrequest is looked at on each rising edge, before it updates
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      bad_count++;
      $display("unexpected waitrequest: expected 0, seen 1");
      end_of_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rdc(input string what, input logic [5:0] a,
                     input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    chk(what, exp, rd);
  endtask : rdc

  task automatic ev(input logic [6:0] e);
    cpu_ev <= cpu_ev | e;
    @(posedge clk);
    cpu_ev <= cpu_ev & ~e;
    @(posedge clk);
  endtask : ev

  // Returns lim+1 when the watched pulse never comes
  task automatic ticks_until(input bit wake, input int lim, output int cnt);
    int base;
    base = wake ? wake_hits : wdt_hits;
    for (cnt = 1; cnt <= lim; cnt++) begin
      low_tick <= 1'b1;
      @(posedge clk);
      low_tick <= 1'b0;
      repeat (2) @(posedge clk);
      if ((wake ? wake_hits : wdt_hits) != base) return;
    end
  endtask : ticks_until

  // Request cleared before the count write, so a write-made edge shows
  task automatic timer_run(input logic [15:0] start, input int cnt);
    wr(msc_pkg::INT_REQUEST_OFS, 32'h0);
    wr(msc_pkg::TIMER_COUNT_OFS, {16'h0, start});
    for (int i = 1; i <= cnt; i++) begin
      timer_tick <= 1'b1;
      @(posedge clk);
      timer_tick <= 1'b0;
      repeat (3) @(posedge clk);
      bus(1'b0, msc_pkg::INT_REQUEST_OFS, 32'h0, rd);
      if (i == cnt || rd[msc_pkg::IRQ_TIMER_BIT] !== 1'b0)
        chk("timer request", 32'(i == cnt), 32'(rd[msc_pkg::IRQ_TIMER_BIT]));
    end
  endtask : timer_run

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  initial begin
    do_reset();
    rdc("clock mode reset", msc_pkg::CLOCK_MODE_OFS, 32'h04);
    rdc("aux reset", msc_pkg::AUX_CONTROL_OFS, 32'h00);
    rdc("timer ctrl reset", msc_pkg::TIMER_CTRL_OFS, 32'h08);
    chk("clk_ctl reset", 32'h01, 32'(clk_ctl));
    wr(6'h3C, 32'hFF);
    rdc("unmapped read", 6'h3C, 32'h00);
    // Supply monitor
    lvr_trip <= 1'b1;
    repeat (8) @(posedge clk);
    chk("lvr before power-on", 32'h0, 32'(lvr_reset));
    por_done <= 1'b1;
    repeat (8) @(posedge clk);
    chk("lvr armed", 32'h1, 32'(lvr_reset));
    wr(msc_pkg::AUX_CONTROL_OFS, 32'h04);
    repeat (3) @(posedge clk);
    chk("lvr disabled", 32'h0, 32'(lvr_reset));
    wr(msc_pkg::AUX_CONTROL_OFS, 32'h00);
    cpu_ev.stop_exe <= 1'b1;
    repeat (8) @(posedge clk);
    chk("lvr in idle halt", 32'h0, 32'(lvr_reset));
    cpu_ev.stop_exe <= 1'b0;
    cpu_ev.stop_sys <= 1'b1;
    repeat (8) @(posedge clk);
    chk("lvr in power down", 32'h0, 32'(lvr_reset));
    lvr_trip <= 1'b0;
    // Wake-up, still in power down
    wr(msc_pkg::PORT_A_WAKE_OFS, 32'h01);
    wr(msc_pkg::AUX_CONTROL_OFS, 32'h20);
    port_a_pins[1] <= 1'b0;
    repeat (8) @(posedge clk);
    ticks_until(1'b1, 60, n);
    chk("wake by disabled pin", 32'h3D, 32'(n));
    port_a_pins[0] <= 1'b0;
    repeat (8) @(posedge clk);
    ticks_until(1'b1, 60, n);
    chk("fast wake ticks", 32'h2D, 32'(n));
    cpu_ev.stop_sys <= 1'b0;
    repeat (4) @(posedge clk);
    cpu_ev.stop_sys <= 1'b1;
    wr(msc_pkg::PORT_B_WAKE_OFS, 32'h01);
    wr(msc_pkg::AUX_CONTROL_OFS, 32'h00);
    port_b_pins[0] <= 1'b0;
    repeat (8) @(posedge clk);
    ticks_until(1'b1, 60, n);
    chk("slow wake ticks", 32'h08, 32'(n));
    cpu_ev.stop_sys <= 1'b0;
    // Pin five
    wr(msc_pkg::PIN5_CTRL_OFS, 32'h03);
    chk("pin5 oe for high", 32'h0, 32'(port_a_pin5_oe));
    chk("pin5 out level", 32'h0, 32'(port_a_pin5_out));
    wr(msc_pkg::PIN5_CTRL_OFS, 32'h02);
    chk("pin5 oe for low", 32'h1, 32'(port_a_pin5_oe));
    wr(msc_pkg::PIN5_CTRL_OFS, 32'h00);
    wr(msc_pkg::CLOCK_MODE_OFS, 32'h05);
    port_a_pins[5] <= 1'b0;
    repeat (8) @(posedge clk);
    chk("pin reset asserted", 32'h1, 32'(external_reset_req));
    port_a_pins[5] <= 1'b1;
    repeat (8) @(posedge clk);
    chk("pin reset released", 32'h0, 32'(external_reset_req));
    wr(msc_pkg::CLOCK_MODE_OFS, 32'h04);
    // Global interrupt enable around a service routine
    ev(EV_SET);
    ev(EV_ENTER);
    // Power-on already seen, so status bit 3 stands as well
    rdc("gie and saved in isr", msc_pkg::STATUS_OFS, 32'h0A);
    ev(EV_RET);
    bus(1'b0, msc_pkg::STATUS_OFS, 32'h0, rd);
    chk("gie after return", 32'h1, 32'(rd[0]));
    ev(EV_CLR);
    ev(EV_ENTER);
    ev(EV_RET);
    bus(1'b0, msc_pkg::STATUS_OFS, 32'h0, rd);
    chk("gie stays off", 32'h0, 32'(rd[0]));
    // Timer edges on counter bit 8
    wr(msc_pkg::INT_ENABLE_OFS, 32'h04);
    wr(msc_pkg::INT_REQUEST_OFS, 32'h00);
    ev(EV_SET);
    wr(msc_pkg::TIMER_CTRL_OFS, 32'h88);
    timer_run(16'h00F8, 8);
    chk("int pending", 32'h1, 32'(int_pending));
    timer_run(16'h02FC, 4);
    wr(msc_pkg::TIMER_COUNT_OFS, 32'h00F0);
    timer_run(16'h01F0, 272);
    wr(msc_pkg::EDGE_SELECT_OFS, 32'h01);
    timer_run(16'h01F8, 8);
    timer_run(16'h03FC, 4);
    // Watchdog periods
    for (int s = 0; s < 4; s++) begin
      wr(msc_pkg::AUX_CONTROL_OFS, 32'(8 + s));
      ev(EV_WDC);
      ticks_until(1'b0, 200, n);
      chk("watchdog period", 32'(per[s]), 32'(n));
    end
    // Safe source switch, then watchdog with slow oscillator off
    wr(msc_pkg::AUX_CONTROL_OFS, 32'h08);
    wr(msc_pkg::CLOCK_MODE_OFS, 32'h36);
    chk("clk_ctl fast halved", 32'h27, 32'(clk_ctl));
    wr(msc_pkg::CLOCK_MODE_OFS, 32'h32);
    chk("clk_ctl slow off", 32'h26, 32'(clk_ctl));
    chk("no hang on safe switch", 32'h0, 32'(cpu_hang));
    ev(EV_WDC);
    ticks_until(1'b0, 40, n);
    chk("watchdog frozen", 32'h29, 32'(n));
    // Unsafe switch from a fresh reset
    do_reset();
    chk("hang after reset", 32'h0, 32'(cpu_hang));
    wr(msc_pkg::CLOCK_MODE_OFS, 32'h50);
    repeat (2) @(posedge clk);
    chk("hang on bad switch", 32'h1, 32'(cpu_hang));
    end_of_test();
  end
endmodule : test_msc_system_control
